//--- design/monitor_alarm_status_regs.sv
// Monitor conversion-ready, alarm and fault status registers for two transmitter pages
`timescale 1ns/1ps
`default_nettype none

module monitor_alarm_status_regs
   import monitor_alarm_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // Register access from the serial slave
   input wire reg_req_t reg_req_i,
   output logic [7:0] reg_rdata_o,
   // Monitor inputs per page
   input wire page_mon_t [NUM_PAGES-1:0] page_mon_i,
   // Supply below power-on analog trip point, asynchronous
   input wire logic power_on_analog_trip_i,
   // Fault output request from shutdown logic: 1 releases the pin
   input wire logic fault_release_i,
   // Open-drain fault output pin
   output logic fault_output_pin_o,
   output logic fault_output_pin_oe_o,
   // Fault interrupt per page
   output logic [NUM_PAGES-1:0] fault_interrupt_o
);

   status_state_t s_q;
   status_state_t s_d;

   always_comb begin
      logic wr_any;
      logic [7:0] rd_val;
      s_d = s_q;
      wr_any = 1'b0;
      rd_val = 8'h00;

      // Only the second and third flops decide; the first only feeds the second
      s_d.poa_sync = {s_q.poa_sync[1:0], power_on_analog_trip_i};
      if (s_q.poa_sync[1] == s_q.poa_sync[2]) begin
         s_d.poa_level = s_q.poa_sync[2];
      end

      // One pin shared by both pages; it is pulled low unless released
      s_d.fault_output_state = fault_release_i;
      s_d.fault_pin_oe = ~fault_release_i;

      for (int p = 0; p < NUM_PAGES; p++) begin
         wr_any = reg_req_i.wr && (reg_req_i.page == p[0]) && (reg_req_i.addr == CONV_READY_OFFSET);
         if (wr_any) begin
            // Only the ready nibble is writable
            s_d.page[p].conv_ready = reg_req_i.wdata[CONV_READY_LSB +: NUM_CHANNELS];
         end
         // Setting after the write lets a completion in the same cycle win
         s_d.page[p].conv_ready = s_d.page[p].conv_ready | page_mon_i[p].conv_done;

         for (int c = 0; c < NUM_CHANNELS; c++) begin
            if (page_mon_i[p].conv_done[c]) begin
               s_d.page[p].alarm[2*c+1] = page_mon_i[p].above_high[c];
               s_d.page[p].alarm[2*c] = page_mon_i[p].below_low[c];
            end
         end
         // Trip point holds supply-low set until a good conversion after it lifts
         if (s_q.poa_level) begin
            s_d.page[p].alarm[2*SUPPLY_CHANNEL] = 1'b1;
         end

         // Fast flags: a comparison in the same cycle as a disable event survives
         if (page_mon_i[p].tx_disable_event) begin
            s_d.page[p].fast_alarm = '0;
         end
         s_d.page[p].fast_alarm = s_d.page[p].fast_alarm | page_mon_i[p].fast_compare;

         s_d.page[p].shutdown_gate = page_mon_i[p].shutdown_gate_signal;
         s_d.page[p].fault_interrupt = (|(s_q.page[p].alarm & page_mon_i[p].alarm_enable))
            | (|(page_mon_i[p].warning_flags & page_mon_i[p].warning_enable))
            | (|s_q.page[p].fast_alarm);
      end

      // Read answer one cycle after the request; unmapped offsets read zero
      case (reg_req_i.addr)
         CONV_READY_OFFSET: begin
            rd_val = {s_q.page[reg_req_i.page].conv_ready, 4'h0};
         end
         MEAS_ALARM_OFFSET: begin
            rd_val = s_q.page[reg_req_i.page].alarm;
         end
         FAULT_STATUS_OFFSET: begin
            rd_val = 8'h00;
            rd_val[FAULT_STATE_BIT] = s_q.fault_output_state;
            rd_val[SHUTDOWN_GATE_BIT] = s_q.page[reg_req_i.page].shutdown_gate;
            rd_val[FAULT_INT_BIT] = s_q.page[reg_req_i.page].fault_interrupt;
         end
         default: begin
            rd_val = 8'h00;
         end
      endcase
      if (reg_req_i.rd) begin
         s_d.rdata = rd_val;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         for (int p = 0; p < NUM_PAGES; p++) begin
            s_q.page[p].conv_ready <= CONV_READY_RESET;
            s_q.page[p].alarm <= MEAS_ALARM_RESET;
            s_q.page[p].fast_alarm <= '0;
            s_q.page[p].shutdown_gate <= FAULT_STATUS_RESET[SHUTDOWN_GATE_BIT];
            s_q.page[p].fault_interrupt <= FAULT_STATUS_RESET[FAULT_INT_BIT];
         end
         s_q.fault_output_state <= FAULT_STATUS_RESET[FAULT_STATE_BIT];
         s_q.fault_pin_oe <= 1'b1;
         s_q.poa_sync <= POA_SYNC_RESET;
         s_q.poa_level <= POA_LEVEL_RESET;
         s_q.rdata <= 8'h00;
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata_o = s_q.rdata;
   assign fault_output_pin_o = 1'b0;
   assign fault_output_pin_oe_o = s_q.fault_pin_oe;
   always_comb begin
      for (int p = 0; p < NUM_PAGES; p++) begin
         fault_interrupt_o[p] = s_q.page[p].fault_interrupt;
      end
   end

endmodule

`default_nettype wire

//--- design/monitor_alarm_pkg.sv
// Package: offsets, reset values, field layouts and carriers of the monitor status registers
package monitor_alarm_pkg;

   // Register offsets within each transmitter page
   localparam logic [7:0] CONV_READY_OFFSET = 8'h6f;
   localparam logic [7:0] MEAS_ALARM_OFFSET = 8'h70;
   localparam logic [7:0] FAULT_STATUS_OFFSET = 8'h71;

   // Values after reset
   localparam logic [3:0] CONV_READY_RESET = 4'h0;
   localparam logic [7:0] MEAS_ALARM_RESET = 8'h10;
   localparam logic [7:0] FAULT_STATUS_RESET = 8'h00;
   localparam logic [2:0] POA_SYNC_RESET = 3'h7;
   localparam logic POA_LEVEL_RESET = 1'b1;

   // Field positions
   localparam int CONV_READY_LSB = 4;
   localparam int FAULT_STATE_BIT = 2;
   localparam int SHUTDOWN_GATE_BIT = 1;
   localparam int FAULT_INT_BIT = 0;

   // Channel index: 3 temperature, 2 supply, 1 bias monitor, 0 power monitor
   localparam int NUM_CHANNELS = 4;
   localparam int SUPPLY_CHANNEL = 2;
   localparam int NUM_PAGES = 2;
   localparam int NUM_FAST = 3;

   // Page select: 0 first transmitter page, 1 second transmitter page
   typedef struct packed {
      logic wr;
      logic rd;
      logic page;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   // Per-page inputs from converter, comparators, enables and shutdown logic
   typedef struct packed {
      logic [NUM_CHANNELS-1:0] conv_done;
      logic [NUM_CHANNELS-1:0] above_high;
      logic [NUM_CHANNELS-1:0] below_low;
      logic [7:0] alarm_enable;
      logic [7:0] warning_flags;
      logic [7:0] warning_enable;
      logic [NUM_FAST-1:0] fast_compare;
      logic tx_disable_event;
      logic shutdown_gate_signal;
   } page_mon_t;

   typedef struct packed {
      logic [NUM_CHANNELS-1:0] conv_ready;
      logic [7:0] alarm;
      logic [NUM_FAST-1:0] fast_alarm;
      logic shutdown_gate;
      logic fault_interrupt;
   } page_state_t;

   typedef struct packed {
      page_state_t [NUM_PAGES-1:0] page;
      logic fault_output_state;
      logic fault_pin_oe;
      logic [2:0] poa_sync;
      logic poa_level;
      logic [7:0] rdata;
   } status_state_t;

endpackage

//--- bench/monitor_alarm_chk_sva.sv
// Assertion checker for the monitor status registers
`timescale 1ns/1ps
`default_nettype none
module monitor_alarm_chk import monitor_alarm_pkg::*; (
   input wire logic core_clk_i, rst_i, power_on_analog_trip_i, fault_release_i,
   input wire logic fault_output_pin_o, fault_output_pin_oe_o,
   input wire reg_req_t reg_req_i,
   input wire page_mon_t [NUM_PAGES-1:0] page_mon_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic [NUM_PAGES-1:0] fault_interrupt_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   logic [1:0] gate_q;
   wire logic rd_rdy = reg_req_i.rd && reg_req_i.addr == 8'h6f;
   wire logic rd_alm = reg_req_i.rd && reg_req_i.addr == 8'h70;
   wire logic rd_flt = reg_req_i.rd && reg_req_i.addr == 8'h71;
   always_ff @(posedge core_clk_i) gate_q <= {page_mon_i[1].shutdown_gate_signal, page_mon_i[0].shutdown_gate_signal};
   a_pin_low: assert property (!fault_output_pin_o) else $error("pin high");
   a_oe_release: assert property (!$past(rst_i) |-> fault_output_pin_oe_o == !$past(fault_release_i))
      else $error("oe wrong");
   a_unmapped_zero: assert property (reg_req_i.rd && !rd_rdy && !rd_alm && !rd_flt |=> !reg_rdata_o)
      else $error("unmapped");
   a_ready_rsv: assert property (rd_rdy |=> reg_rdata_o[3:0] == 4'h0) else $error("ready low");
   a_fault_state: assert property (rd_flt |=> reg_rdata_o[7:2] == {5'h00, !$past(fault_output_pin_oe_o)})
      else $error("fault state");
   a_gate_mirror: assert property (rd_flt && !$past(rst_i) |=> reg_rdata_o[1] == $past(gate_q[reg_req_i.page]))
      else $error("gate");
   a_irq_bit: assert property (rd_flt |=> reg_rdata_o[0] == $past(fault_interrupt_o[reg_req_i.page]))
      else $error("irq bit");
   a_trip_low: assert property (power_on_analog_trip_i [*8] ##0 rd_alm |=> reg_rdata_o[4]) else $error("trip");
   a_ready_set: assert property (page_mon_i[0].conv_done[3] ##1 !reg_req_i.wr ##1
      (rd_rdy && !reg_req_i.page && !reg_req_i.wr) |=> reg_rdata_o[7]) else $error("ready");
   c_irq: cover property (rd_flt ##1 reg_rdata_o[0]);
   c_trip: cover property (power_on_analog_trip_i && rd_alm);
   c_conv: cover property (page_mon_i[1].conv_done != 4'h0);
endmodule
bind monitor_alarm_status_regs monitor_alarm_chk chk_u (.*);
`default_nettype wire

//--- bench/monitor_host_model.sv
// Host side model: byte accesses from the serial slave
`timescale 1ns/1ps
`default_nettype none
module monitor_host_model import monitor_alarm_pkg::*; (
   input wire logic core_clk_i,
   input wire logic [7:0] rdata_i,
   output var reg_req_t req_o
);
   initial req_o = '0;
   task automatic access(input logic w, pg, input logic [7:0] a, d, output logic [7:0] q);
      @(negedge core_clk_i);
      req_o = '{w, !w, pg, a, d};
      @(negedge core_clk_i);
      q = rdata_i;
      // Idle lines invert so a stale address never looks held
      req_o = '{1'b0, 1'b0, !pg, ~a, ~d};
   endtask
endmodule
`default_nettype wire

//--- bench/monitor_alarm_status_regs_test.sv
// Bench for the monitor status registers
`timescale 1ns/1ps
`default_nettype none
module monitor_alarm_status_regs_test import monitor_alarm_pkg::*;;
   logic core_clk_i = 0, rst_i = 1, trip = 1, rel = 0, pin, oe;
   logic [7:0] q, e, alm[2] = '{8'h10, 8'h10};
   logic [3:0] rdy[2] = '{0, 0};
   logic [2:0] fst[2] = '{0, 0};
   logic [1:0] irq;
   logic [31:0] seed = 32'h3e3e;
   int num_errors = 0, cmp_count = 0;
   reg_req_t req;
   page_mon_t [1:0] mon = '0;
   monitor_alarm_status_regs dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_req_i(req), .reg_rdata_o(q),
      .page_mon_i(mon), .power_on_analog_trip_i(trip), .fault_release_i(rel), .fault_output_pin_o(pin),
      .fault_output_pin_oe_o(oe), .fault_interrupt_o(irq));
   monitor_host_model host_u (.core_clk_i(core_clk_i), .rdata_i(q), .req_o(req));
   initial forever #5 core_clk_i = ~core_clk_i;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(input string s, input logic [7:0] x, y);
      cmp_count++;
      if (y !== x) begin
         num_errors++;
         $display("CHECK FAILED %s exp %h got %h", s, x, y);
      end
   endtask
   task automatic rd(input int p, input logic [7:0] a, x);
      logic [7:0] v;
      host_u.access(1'b0, p[0], a, 8'h00, v);
      check("rdata", x, v);
   endtask
   task automatic pulse(input int p);
      for (int c = 0; c < 4; c++) begin
         if (mon[p].conv_done[c]) begin
            rdy[p][c] = 1'b1;
            alm[p][2*c+1] = mon[p].above_high[c];
            alm[p][2*c] = mon[p].below_low[c];
         end
      end
      alm[p][4] |= trip;
      fst[p] = (mon[p].tx_disable_event ? 3'h0 : fst[p]) | mon[p].fast_compare;
      @(negedge core_clk_i);
      mon[p].conv_done = 4'h0;
      mon[p].fast_compare = 3'h0;
      mon[p].tx_disable_event = 1'b0;
   endtask
   task automatic final_report();
      $display("compares %0d errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #100us;
      num_errors++;
      final_report();
   end
   initial begin
      int p;
      logic [63:0] r;
      repeat (6) @(posedge core_clk_i);
      @(negedge core_clk_i);
      rst_i = 0;
      trip = 0;
      for (p = 0; p < 2; p++) begin
         rd(p, 8'h6f, 8'h00);
         rd(p, 8'h70, 8'h10);
         rd(p, 8'h71, 8'h00);
         rd(p, 8'h72, 8'h00);
      end
      repeat (60) begin
         p = rnd() % 2;
         r = {rnd(), rnd()};
         @(negedge core_clk_i);
         mon[p] = r[40:0];
         rel = r[63];
         if (r[62]) mon[p].warning_enable = 8'h00;
         pulse(p);
         if (r[61]) begin
            host_u.access(1'b1, p[0], 8'h6f, r[48:41], e);
            rdy[p] = r[48:45];
            host_u.access(1'b1, p[0], 8'h70, r[48:41], e);
         end
         e = {5'h00, rel, mon[p].shutdown_gate_signal, |(alm[p] & mon[p].alarm_enable) | |fst[p]
            | |(mon[p].warning_flags & mon[p].warning_enable)};
         rd(p, 8'h6f, {rdy[p], 4'h0});
         rd(p, 8'h70, alm[p]);
         rd(p, 8'h71, e);
         check("irq", {7'h00, e[0]}, {7'h00, irq[p]});
         check("oe", {7'h00, !rel}, {7'h00, oe});
      end
      trip = 1;
      repeat (8) @(negedge core_clk_i);
      alm[1][4] = 1'b1;
      rd(1, 8'h70, alm[1]);
      mon[0].conv_done = 4'h4;
      mon[0].below_low = 4'h0;
      pulse(0);
      trip = 0;
      repeat (8) @(negedge core_clk_i);
      rd(0, 8'h70, alm[0]);
      mon[0].conv_done = 4'h4;
      pulse(0);
      rd(0, 8'h70, alm[0]);
      final_report();
   end
endmodule
`default_nettype wire
